// File: rtl/dtm_pin_fall.sv
// synchroniser and falling edge detector for an external count pin
`timescale 1ns/10ps
module dtm_pin_fall (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pin and detected edge
	input wire logic pin_in,
	output logic fall_pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// meta_q feeds sync_q only; edge logic sees the settled copies
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			last_q <= 1'b1;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign fall_pulse = last_q & ~sync_q;
endmodule

// File: rtl/dtm_pkg.sv
// shared constants and types of the dual timer block
package dtm_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DTM_ADDR_CTRL = 8'h88;
	localparam logic [7:0] DTM_ADDR_MODE = 8'h89;
	localparam logic [7:0] DTM_ADDR_LO0 = 8'h8a;
	localparam logic [7:0] DTM_ADDR_LO1 = 8'h8b;
	localparam logic [7:0] DTM_ADDR_HI0 = 8'h8c;
	localparam logic [7:0] DTM_ADDR_HI1 = 8'h8d;
	localparam logic [7:0] DTM_ADDR_PRESC = 8'h8e;
	localparam logic [7:0] DTM_ADDR_EN = 8'ha8;
	localparam logic [7:0] DTM_ADDR_PRI = 8'hb8;
	localparam logic [7:0] DTM_ADDR_STAT = 8'he8;
	localparam logic [7:0] DTM_ADDR_MASK = 8'he9;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int DTM_CTRL_FLAG1 = 7;
	localparam int DTM_CTRL_RUN1 = 6;
	localparam int DTM_CTRL_FLAG0 = 5;
	localparam int DTM_CTRL_RUN0 = 4;
	localparam int DTM_MODE_SRC1 = 6;
	localparam int DTM_MODE_M1_LO = 4;
	localparam int DTM_MODE_SRC0 = 2;
	localparam int DTM_MODE_M0_LO = 0;
	localparam int DTM_PRESC_FD1 = 1;
	localparam int DTM_PRESC_FD0 = 0;
	localparam int DTM_EN_T1 = 3;
	localparam int DTM_EN_T0 = 1;
	localparam int DTM_PRI_T1 = 3;
	localparam int DTM_PRI_T0 = 1;
	localparam int DTM_STAT_OV0 = 0;
	localparam int DTM_STAT_OV1 = 1;

	// ------------------------------------------------------------
	// writable masks, reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] DTM_MODE_WMASK = 8'h77;
	localparam logic [7:0] DTM_CTRL_WMASK = 8'hf0;
	localparam logic [7:0] DTM_PRESC_WMASK = 8'h03;
	localparam logic [7:0] DTM_EN_WMASK = 8'h0a;
	localparam logic [7:0] DTM_PRI_WMASK = 8'h0a;
	localparam logic [1:0] DTM_STAT_WMASK = 2'h3;
	localparam logic [7:0] DTM_RST_BYTE = 8'h00;
	localparam logic [3:0] DTM_PRESC_DIV = 4'hc;
	localparam logic [3:0] DTM_PRESC_LAST = DTM_PRESC_DIV - 4'h1;

	// mode field codes in encoding order
	typedef enum logic [1:0] {
		DTM_MODE13,
		DTM_MODE16,
		DTM_MODE8R,
		DTM_MODE_SPLIT
	} dtm_mode_t;

endpackage

// File: rtl/dtm_top.sv
// two 16-bit timer/counters with mode, prescale and interrupt control
// ------------------------------------------------------------
// Summary of operation
// - timer1 source select: clear counts the prescaled clock, set counts its pin pulses.
// - timer0 source select: clear counts the prescaled clock, set counts its pin pulses.
// - timer1 modes: 13-bit, 16-bit, 8-bit auto-reload, code 11 stops it.
// - timer0 modes: 13-bit, 16-bit, 8-bit auto-reload from high byte.
// - timer0 code 11 splits it; high byte uses timer1 run bit and flag.
// - apart from the timer0 split high byte, each timer counts only while its run bit is set, else holds.
// - timer1 prescale bit: clear gives clock divided by twelve, set undivided.
// - timer0 prescale bit: clear gives clock divided by twelve, set undivided.
// - enable bit 3 passes or blocks the timer1 interrupt request.
// - enable bit 1 passes or blocks the timer0 interrupt request.
// - priority bit 3 presents timer1 interrupt at low or high priority.
// - priority bit 1 presents timer0 interrupt at low or high priority.
// - overflow sets the timer flag; interrupt acceptance clears it.
// - counter mode increments by one on each falling pin edge.
// - setting a run bit keeps the count; counting resumes from it.
// - timer0 split mode halts timer1 counting in every timer1 mode.
// ------------------------------------------------------------
`timescale 1ns/10ps
module dtm_top
	import dtm_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// external count pins
	input wire logic t0_pin,
	input wire logic t1_pin,
	// processor interrupt handshake
	input wire logic t0_irq_ack,
	input wire logic t1_irq_ack,
	output logic t0_irq_req,
	output logic t0_irq_high,
	output logic t1_irq_req,
	output logic t1_irq_high,
	// summary interrupt
	output logic irq
);
	import dtm_pkg::*;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [7:0] mode_q;
	logic [7:0] presc_reg_q;
	logic [7:0] en_q;
	logic [7:0] pri_q;
	logic [1:0] stat_q;
	logic [1:0] stat_d;
	logic [1:0] mask_q;
	logic run0_q;
	logic run1_q;
	logic flag0_q;
	logic flag0_d;
	logic flag1_q;
	logic flag1_d;
	logic [7:0] lo0_q;
	logic [7:0] lo0_d;
	logic [7:0] hi0_q;
	logic [7:0] hi0_d;
	logic [7:0] lo1_q;
	logic [7:0] lo1_d;
	logic [7:0] hi1_q;
	logic [7:0] hi1_d;
	logic [3:0] div_q;
	logic [7:0] rd_data_q;
	logic t0_req_q;
	logic t0_high_q;
	logic t1_req_q;
	logic t1_high_q;
	logic irq_q;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire wr_ctrl = wr_en && (addr == DTM_ADDR_CTRL);
	wire wr_mode = wr_en && (addr == DTM_ADDR_MODE);
	wire wr_lo0 = wr_en && (addr == DTM_ADDR_LO0);
	wire wr_lo1 = wr_en && (addr == DTM_ADDR_LO1);
	wire wr_hi0 = wr_en && (addr == DTM_ADDR_HI0);
	wire wr_hi1 = wr_en && (addr == DTM_ADDR_HI1);
	wire wr_presc = wr_en && (addr == DTM_ADDR_PRESC);
	wire wr_irq_en = wr_en && (addr == DTM_ADDR_EN);
	wire wr_irq_pri = wr_en && (addr == DTM_ADDR_PRI);
	wire wr_stat = wr_en && (addr == DTM_ADDR_STAT);
	wire wr_mask = wr_en && (addr == DTM_ADDR_MASK);
	wire wr_cnt0 = wr_lo0 || wr_hi0;
	wire wr_cnt1 = wr_lo1 || wr_hi1;

	wire [7:0] ctrl_view = {flag1_q, run1_q, flag0_q, run0_q, 4'h0};
	wire [7:0] rd_sel =
		(addr == DTM_ADDR_CTRL) ? ctrl_view :
		(addr == DTM_ADDR_MODE) ? mode_q :
		(addr == DTM_ADDR_LO0) ? lo0_q :
		(addr == DTM_ADDR_LO1) ? lo1_q :
		(addr == DTM_ADDR_HI0) ? hi0_q :
		(addr == DTM_ADDR_HI1) ? hi1_q :
		(addr == DTM_ADDR_PRESC) ? presc_reg_q :
		(addr == DTM_ADDR_EN) ? en_q :
		(addr == DTM_ADDR_PRI) ? pri_q :
		(addr == DTM_ADDR_STAT) ? {6'h00, stat_q} :
		(addr == DTM_ADDR_MASK) ? {6'h00, mask_q} : 8'h00;

	// ------------------------------------------------------------
	// count sources
	// ------------------------------------------------------------
	logic fall0;
	logic fall1;

	dtm_pin_fall u_fall0 (
		.clock(clock),
		.rst(rst),
		.pin_in(t0_pin),
		.fall_pulse(fall0)
	);

	dtm_pin_fall u_fall1 (
		.clock(clock),
		.rst(rst),
		.pin_in(t1_pin),
		.fall_pulse(fall1)
	);

	// one shared divider keeps both timers phase aligned at fsys/12
	wire tick12 = (div_q == DTM_PRESC_LAST);
	wire tmr_tick0 = presc_reg_q[DTM_PRESC_FD0] ? 1'b1 : tick12;
	wire tmr_tick1 = presc_reg_q[DTM_PRESC_FD1] ? 1'b1 : tick12;
	wire src_tick0 = mode_q[DTM_MODE_SRC0] ? fall0 : tmr_tick0;
	wire src_tick1 = mode_q[DTM_MODE_SRC1] ? fall1 : tmr_tick1;

	dtm_mode_t mode0;
	dtm_mode_t mode1;
	assign mode0 = dtm_mode_t'(mode_q[DTM_MODE_M0_LO +: 2]);
	assign mode1 = dtm_mode_t'(mode_q[DTM_MODE_M1_LO +: 2]);
	wire split = (mode0 == DTM_MODE_SPLIT);

	wire inc0 = run0_q && src_tick0;
	// split high byte is timer only and runs from timer1's run bit
	wire inc_hi0 = split && run1_q && tmr_tick0;
	wire inc1 = run1_q && src_tick1 && !split && (mode1 != DTM_MODE_SPLIT);

	// ------------------------------------------------------------
	// increment arithmetic
	// ------------------------------------------------------------
	wire [13:0] t0_13n = {1'b0, hi0_q, lo0_q[4:0]} + 14'h0001;
	wire [16:0] t0_16n = {1'b0, hi0_q, lo0_q} + 17'h00001;
	wire [8:0] lo0_8n = {1'b0, lo0_q} + 9'h001;
	wire [8:0] hi0_8n = {1'b0, hi0_q} + 9'h001;
	wire [13:0] t1_13n = {1'b0, hi1_q, lo1_q[4:0]} + 14'h0001;
	wire [16:0] t1_16n = {1'b0, hi1_q, lo1_q} + 17'h00001;
	wire [8:0] lo1_8n = {1'b0, lo1_q} + 9'h001;

	logic ov0;
	logic ov_hi0;
	logic ov1;

	// ------------------------------------------------------------
	// timer 0 next state; a register write beats an increment
	// ------------------------------------------------------------
	always_comb
	begin
		lo0_d = lo0_q;
		hi0_d = hi0_q;
		ov0 = 1'b0;
		ov_hi0 = 1'b0;
		if (inc0)
		begin
			unique case (mode0)
				DTM_MODE13:
				begin
					// upper three low-byte bits are left alone
					lo0_d = {lo0_q[7:5], t0_13n[4:0]};
					hi0_d = t0_13n[12:5];
					ov0 = t0_13n[13];
				end
				DTM_MODE16:
				begin
					lo0_d = t0_16n[7:0];
					hi0_d = t0_16n[15:8];
					ov0 = t0_16n[16];
				end
				DTM_MODE8R:
				begin
					lo0_d = lo0_8n[8] ? hi0_q : lo0_8n[7:0];
					ov0 = lo0_8n[8];
				end
				DTM_MODE_SPLIT:
				begin
					lo0_d = lo0_8n[7:0];
					ov0 = lo0_8n[8];
				end
			endcase
		end
		if (inc_hi0)
		begin
			hi0_d = hi0_8n[7:0];
			ov_hi0 = hi0_8n[8];
		end
		if (wr_lo0)
		begin
			lo0_d = wr_data;
		end
		if (wr_hi0)
		begin
			hi0_d = wr_data;
		end
	end

	// ------------------------------------------------------------
	// timer 1 next state
	// ------------------------------------------------------------
	always_comb
	begin
		lo1_d = lo1_q;
		hi1_d = hi1_q;
		ov1 = 1'b0;
		if (inc1)
		begin
			unique case (mode1)
				DTM_MODE13:
				begin
					lo1_d = {lo1_q[7:5], t1_13n[4:0]};
					hi1_d = t1_13n[12:5];
					ov1 = t1_13n[13];
				end
				DTM_MODE16:
				begin
					lo1_d = t1_16n[7:0];
					hi1_d = t1_16n[15:8];
					ov1 = t1_16n[16];
				end
				DTM_MODE8R:
				begin
					lo1_d = lo1_8n[8] ? hi1_q : lo1_8n[7:0];
					ov1 = lo1_8n[8];
				end
				DTM_MODE_SPLIT:
				begin
					// stopped: inc1 is already low for this code
					lo1_d = lo1_q;
				end
			endcase
		end
		if (wr_lo1)
		begin
			lo1_d = wr_data;
		end
		if (wr_hi1)
		begin
			hi1_d = wr_data;
		end
	end

	// ------------------------------------------------------------
	// flags: a hardware set wins over software write and acceptance
	// ------------------------------------------------------------
	wire set_flag0 = ov0;
	wire set_flag1 = ov1 || ov_hi0;
	assign flag0_d = set_flag0 || (wr_ctrl ? wr_data[DTM_CTRL_FLAG0] : (flag0_q && !t0_irq_ack));
	assign flag1_d = set_flag1 || (wr_ctrl ? wr_data[DTM_CTRL_FLAG1] : (flag1_q && !t1_irq_ack));
	wire [1:0] stat_set = {set_flag1, set_flag0};
	wire [1:0] stat_clr = wr_stat ? (wr_data[1:0] & DTM_STAT_WMASK) : 2'h0;
	assign stat_d = stat_set | (stat_q & ~stat_clr);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode_q <= DTM_RST_BYTE;
			presc_reg_q <= DTM_RST_BYTE;
			en_q <= DTM_RST_BYTE;
			pri_q <= DTM_RST_BYTE;
			run0_q <= 1'b0;
			run1_q <= 1'b0;
		end
		else
		begin
			if (wr_mode)
				mode_q <= wr_data & DTM_MODE_WMASK;
			if (wr_presc)
				presc_reg_q <= wr_data & DTM_PRESC_WMASK;
			if (wr_irq_en)
				en_q <= wr_data & DTM_EN_WMASK;
			if (wr_irq_pri)
				pri_q <= wr_data & DTM_PRI_WMASK;
			if (wr_ctrl)
			begin
				// run bits never touch the count
				run0_q <= wr_data[DTM_CTRL_RUN0];
				run1_q <= wr_data[DTM_CTRL_RUN1];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			lo0_q <= DTM_RST_BYTE;
			hi0_q <= DTM_RST_BYTE;
			lo1_q <= DTM_RST_BYTE;
			hi1_q <= DTM_RST_BYTE;
			flag0_q <= 1'b0;
			flag1_q <= 1'b0;
			stat_q <= 2'h0;
			mask_q <= 2'h0;
			div_q <= 4'h0;
		end
		else
		begin
			lo0_q <= lo0_d;
			hi0_q <= hi0_d;
			lo1_q <= lo1_d;
			hi1_q <= hi1_d;
			flag0_q <= flag0_d;
			flag1_q <= flag1_d;
			stat_q <= stat_d;
			if (wr_mask)
				mask_q <= wr_data[1:0] & DTM_STAT_WMASK;
			div_q <= tick12 ? 4'h0 : div_q + 4'h1;
		end
	end

	// outputs all come from flip-flops, one cycle behind their cause
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rd_data_q <= 8'h00;
			t0_req_q <= 1'b0;
			t0_high_q <= 1'b0;
			t1_req_q <= 1'b0;
			t1_high_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			rd_data_q <= rd_en ? rd_sel : 8'h00;
			t0_req_q <= flag0_q && en_q[DTM_EN_T0];
			t1_req_q <= flag1_q && en_q[DTM_EN_T1];
			t0_high_q <= pri_q[DTM_PRI_T0];
			t1_high_q <= pri_q[DTM_PRI_T1];
			irq_q <= |(stat_q & mask_q);
		end
	end

	assign rd_data = rd_data_q;
	assign t0_irq_req = t0_req_q;
	assign t0_irq_high = t0_high_q;
	assign t1_irq_req = t1_req_q;
	assign t1_irq_high = t1_high_q;
	assign irq = irq_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	wire [15:0] cnt0 = {hi0_q, lo0_q};
	wire [15:0] cnt1 = {hi1_q, lo1_q};

	property p_hold0;
		(!run0_q && !split && !wr_cnt0) |=> (cnt0 == $past(cnt0));
	endproperty
	a_hold0: assert property (p_hold0) else $error("timer0 moved while stopped");

	property p_resume0;
		(wr_ctrl && wr_data[DTM_CTRL_RUN0] && !run0_q && !wr_cnt0 && !split)
			|=> (cnt0 == $past(cnt0)) && run0_q;
	endproperty
	a_resume0: assert property (p_resume0) else $error("run set disturbed count");

	property p_pin0;
		(run0_q && mode_q[DTM_MODE_SRC0] && mode0 == DTM_MODE16 && fall0
			&& !wr_cnt0 && cnt0 != 16'hffff) |=> (cnt0 == $past(cnt0) + 16'h0001);
	endproperty
	a_pin0: assert property (p_pin0) else $error("timer0 missed pin edge");

	property p_pin1;
		(run1_q && mode_q[DTM_MODE_SRC1] && mode1 == DTM_MODE16 && !split && fall1
			&& !wr_cnt1 && cnt1 != 16'hffff) |=> (cnt1 == $past(cnt1) + 16'h0001);
	endproperty
	a_pin1: assert property (p_pin1) else $error("timer1 missed pin edge");

	property p_fast0;
		(run0_q && !mode_q[DTM_MODE_SRC0] && presc_reg_q[DTM_PRESC_FD0]
			&& mode0 == DTM_MODE16 && !wr_cnt0 && cnt0 != 16'hffff)
			|=> (cnt0 == $past(cnt0) + 16'h0001);
	endproperty
	a_fast0: assert property (p_fast0) else $error("timer0 undivided clock wrong");

	property p_slow1;
		(run1_q && !mode_q[DTM_MODE_SRC1] && !presc_reg_q[DTM_PRESC_FD1]
			&& mode1 == DTM_MODE16 && !split && !wr_cnt1 && !wr_presc && !wr_mode
			&& div_q == 4'h0) |=> (cnt1 == $past(cnt1)) [*8];
	endproperty
	a_slow1: assert property (p_slow1) else $error("timer1 ran faster than fsys/12");

	property p_stop1;
		(mode1 == DTM_MODE_SPLIT && !wr_cnt1) |=> (cnt1 == $past(cnt1));
	endproperty
	a_stop1: assert property (p_stop1) else $error("timer1 counted in stop code");

	property p_halt1;
		(split && !wr_cnt1) |=> (cnt1 == $past(cnt1));
	endproperty
	a_halt1: assert property (p_halt1) else $error("timer1 counted during split");

	property p_reload0;
		(mode0 == DTM_MODE8R && inc0 && lo0_q == 8'hff && !wr_cnt0)
			|=> (lo0_q == $past(hi0_q)) && (hi0_q == $past(hi0_q)) && flag0_q;
	endproperty
	a_reload0: assert property (p_reload0) else $error("timer0 reload failed");

	property p_split_hi;
		(split && run1_q && tmr_tick0 && hi0_q == 8'hff && !wr_hi0 && !wr_ctrl)
			|=> (hi0_q == 8'h00) && flag1_q;
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split high byte overflow");

	property p_ack0;
		(t0_irq_ack && !set_flag0 && !wr_ctrl) |=> !flag0_q ##1 !t0_irq_req;
	endproperty
	a_ack0: assert property (p_ack0) else $error("acceptance left timer0 flag");

	property p_req0;
		(flag0_q && en_q[DTM_EN_T0] && pri_q[DTM_PRI_T0]) |=> t0_irq_req && t0_irq_high;
	endproperty
	a_req0: assert property (p_req0) else $error("timer0 request not raised high");

	property p_mask1;
		(!en_q[DTM_EN_T1] && !wr_irq_en) |=> !t1_irq_req;
	endproperty
	a_mask1: assert property (p_mask1) else $error("timer1 request leaked");

	property p_low1;
		(flag1_q && en_q[DTM_EN_T1] && !pri_q[DTM_PRI_T1]) |=> t1_irq_req && !t1_irq_high;
	endproperty
	a_low1: assert property (p_low1) else $error("timer1 priority wrong");
endmodule

// File: testbench/dtm_pin_model.sv
// pulse source standing in for the two external count pins
`timescale 1ns/10ps
module dtm_pin_model (
	// clock
	input wire logic clock,
	// one-cycle pulse requests, one per pin
	input wire logic [1:0] go,
	// count pins, high when idle as if pulled up
	output logic [1:0] pin
);
	initial pin = 2'b11;
	for (genvar k = 0; k < 2; k++)
	begin : g_pin
		// low for three cycles so the pin synchroniser cannot miss the pulse
		always @(posedge clock)
		begin
			if (go[k])
			begin
				pin[k] <= 1'b0;
				repeat (3) @(posedge clock);
				pin[k] <= 1'b1;
			end
		end
	end
endmodule

// File: testbench/dtm_top_bench.sv
// self-checking bench of the dual timer block
`timescale 1ns/10ps
module dtm_top_bench;
	import dtm_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic irq;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic [1:0] go = 2'b00;
	logic [1:0] ack = 2'b00;
	logic [1:0] pin;
	logic [1:0] req;
	logic [1:0] high;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	logic [7:0] ra [11] = '{DTM_ADDR_CTRL, DTM_ADDR_MODE, DTM_ADDR_LO0, DTM_ADDR_LO1,
		DTM_ADDR_HI0, DTM_ADDR_HI1, DTM_ADDR_PRESC, DTM_ADDR_EN, DTM_ADDR_PRI,
		DTM_ADDR_STAT, DTM_ADDR_MASK};
	// ctrl and status get zero: ones would start timers or clear nothing useful
	logic [7:0] wd [11] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'h00, 8'hff};
	logic [7:0] we [11] = '{8'h00, 8'h77, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h0a,
		8'h0a, 8'h00, 8'h03};

	// ------------------------------------------------------------
	// design, pin partner, clock and time limit
	// ------------------------------------------------------------
	dtm_top i_dtm_top (
		.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .t0_pin(pin[0]), .t1_pin(pin[1]),
		.t0_irq_ack(ack[0]), .t1_irq_ack(ack[1]), .t0_irq_req(req[0]),
		.t0_irq_high(high[0]), .t1_irq_req(req[1]), .t1_irq_high(high[1]), .irq(irq)
	);
	dtm_pin_model i_dtm_pin_model (.clock(clock), .go(go), .pin(pin));

	initial forever #10 clock = ~clock;

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			$display("wrong value at %0t: run did not finish", $time);
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// an idle edge follows every strobe so no strobe is assigned twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 chk(rd_data, exp);
		@(posedge clock);
		#1 chk(rd_data, 8'h00);
	endtask

	task automatic ochk(input int i, input logic [2:0] e);
		#1 chk({5'h00, req[i], high[i], irq}, {5'h00, e});
	endtask

	// counts run from the run write to the stop write: 7 * np + m + 2 clock edges
	task automatic run_chk(input int i, input logic [1:0] c, input logic fast,
		input logic src, input logic run, input int np, input int m,
		input logic [7:0] th, input logic [7:0] tl, input logic [7:0] eth,
		input logic [7:0] etl);
		wr(DTM_ADDR_MODE, 8'({src, c}) << (4 * i));
		wr(DTM_ADDR_PRESC, 8'(fast) << i);
		wr(DTM_ADDR_HI0 + 8'(i), th);
		wr(DTM_ADDR_LO0 + 8'(i), tl);
		wr(DTM_ADDR_CTRL, 8'(run) << (4 + 2 * i));
		repeat (np)
		begin
			go[i] <= 1'b1;
			@(posedge clock);
			go[i] <= 1'b0;
			repeat (6) @(posedge clock);
		end
		repeat (m) @(posedge clock);
		wr(DTM_ADDR_CTRL, 8'h00);
		rd(DTM_ADDR_HI0 + 8'(i), eth);
		rd(DTM_ADDR_LO0 + 8'(i), etl);
	endtask

	task automatic ovf(input int i);
		wr(DTM_ADDR_STAT, 8'h03);
		wr(DTM_ADDR_MODE, 8'h01 << (4 * i));
		wr(DTM_ADDR_PRESC, 8'h01 << i);
		wr(DTM_ADDR_EN, 8'h02 << (2 * i));
		wr(DTM_ADDR_PRI, 8'h02 << (2 * i));
		wr(DTM_ADDR_MASK, 8'h01 << i);
		wr(DTM_ADDR_HI0 + 8'(i), 8'hff);
		wr(DTM_ADDR_LO0 + 8'(i), 8'hfe);
		wr(DTM_ADDR_CTRL, 8'h10 << (2 * i));
		repeat (3) @(posedge clock);
		ochk(i, 3'h7);
		rd(DTM_ADDR_STAT, 8'h01 << i);
		wr(DTM_ADDR_MASK, 8'h00);
		ochk(i, 3'h6);
		wr(DTM_ADDR_EN, 8'h00);
		ochk(i, 3'h2);
		wr(DTM_ADDR_PRI, 8'h00);
		ochk(i, 3'h0);
		wr(DTM_ADDR_EN, 8'h02 << (2 * i));
		ochk(i, 3'h4);
		ack[i] <= 1'b1;
		@(posedge clock);
		ack[i] <= 1'b0;
		@(posedge clock);
		ochk(i, 3'h0);
		rd(DTM_ADDR_CTRL, 8'h10 << (2 * i));
		wr(DTM_ADDR_STAT, 8'h01 << i);
		rd(DTM_ADDR_STAT, 8'h00);
		wr(DTM_ADDR_CTRL, 8'h00);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (int k = 0; k < 11; k++)
			rd(ra[k], 8'h00);
		for (int k = 0; k < 11; k++)
		begin
			wr(ra[k], wd[k]);
			rd(ra[k], we[k]);
			wr(ra[k], 8'h00);
		end
		rd(8'h00, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			run_chk(i, 2'h1, 1, 0, 1, 0, 3, 8'h00, 8'hfe, 8'h01, 8'h03);
			run_chk(i, 2'h0, 1, 0, 1, 0, 3, 8'h00, 8'hfe, 8'h01, 8'he3);
			run_chk(i, 2'h2, 1, 0, 1, 0, 3, 8'h80, 8'hfe, 8'h80, 8'h83);
			run_chk(i, 2'h1, 0, 0, 1, 0, 22, 8'h00, 8'h10, 8'h00, 8'h12);
			run_chk(i, 2'h1, 1, 1, 1, 3, 3, 8'h00, 8'h10, 8'h00, 8'h13);
			run_chk(i, 2'h1, 1, 0, 0, 0, 3, 8'h00, 8'h10, 8'h00, 8'h10);
			ovf(i);
		end
		run_chk(1, 2'h3, 1, 0, 1, 0, 3, 8'h00, 8'h10, 8'h00, 8'h10);
		wr(DTM_ADDR_MODE, 8'h03);
		wr(DTM_ADDR_PRESC, 8'h01);
		wr(DTM_ADDR_HI0, 8'h10);
		wr(DTM_ADDR_LO0, 8'h20);
		wr(DTM_ADDR_LO1, 8'h30);
		wr(DTM_ADDR_CTRL, 8'h40);
		repeat (3) @(posedge clock);
		wr(DTM_ADDR_CTRL, 8'h00);
		rd(DTM_ADDR_HI0, 8'h15);
		rd(DTM_ADDR_LO0, 8'h20);
		rd(DTM_ADDR_LO1, 8'h30);
		wr(DTM_ADDR_HI0, 8'hff);
		wr(DTM_ADDR_CTRL, 8'h40);
		rd(DTM_ADDR_CTRL, 8'hc0);
		rd(DTM_ADDR_STAT, 8'h02);
		give_verdict();
	end
endmodule
